// ### include/sdpcs_map.vh
// Purpose: register map and field constants for the serdes pcs ability/status bank
// Assumes: 16-bit registers, one aligned 32-bit word each on avalon-mm
// Notes: byte address is four times the register index
`ifndef SDPCS_MAP_VH
`define SDPCS_MAP_VH
`define SDPCS_IDX_MAC_ADV 5'h12
`define SDPCS_IDX_MAC_LP 5'h13
`define SDPCS_IDX_MAC_STAT 5'h14
`define SDPCS_IDX_TX_GOOD 5'h15
`define SDPCS_IDX_TX_CRC 5'h16
`define SDPCS_IDX_MEDIA_CTL 5'h17
`define SDPCS_IDX_MAC_CTL 5'h10
`define SDPCS_IDX_MEDIA_ADV 5'h19
`define SDPCS_MAC_ADV_RST 16'h0000
`define SDPCS_MEDIA_ADV_RST 16'h0000
`define SDPCS_MAC_CTL_RST 1'h0
`define SDPCS_SEL_RST 2'h0
`define SDPCS_PFIX_RST 1'h0
`define SDPCS_PD_RST 1'h0
`define SDPCS_NOCE_RST 1'h1
`define SDPCS_FADV_RST 1'h0
`define SDPCS_POL_RST 1'h0
`define SDPCS_ODD_RST 1'h1
`define SDPCS_HLS_RST 1'h0
`define SDPCS_FEFI_RST 1'h0
`define SDPCS_SEL_MEDIA 2'h0
`define SDPCS_SEL_MAC 2'h1
`define SDPCS_GOOD_MOD 14'h270F
`define SDPCS_CRC_MAX 8'hFF
`define SDPCS_MAC_CTL_FADV 11
`define SDPCS_SEL_HI 15
`define SDPCS_SEL_LO 14
`define SDPCS_PFIX_BIT 13
`define SDPCS_PD_BIT 13
`define SDPCS_NOCE_BIT 12
`define SDPCS_FADV_BIT 11
`define SDPCS_POLIN_BIT 6
`define SDPCS_POLOUT_BIT 5
`define SDPCS_ODD_BIT 4
`define SDPCS_HLS_BIT 2
`define SDPCS_FFEFI_BIT 1
`define SDPCS_FEFIV_BIT 0
`define SDPCS_ADDR_HI 6
`define SDPCS_ADDR_LO 2
`endif

// ### logic/sdpcs_regs.v
// Purpose: serdes pcs ability, status, tx counter and media control registers
// Assumes: avalon-mm slave, one-cycle waitrequest on reads, zero wait on writes
// Notes: pcs datapath lives outside; this bank exports controls and takes events
// Functional notes
// - mac advertised word resets to zero, writable only while mac force bit set
// - without mac force bit the advertised word read value is not to be trusted
// - mac partner ability is read-only and holds the latest received word
// - status bit 15 latches comma realignment until read, then clears
// - status bit 14 latches signal detection until read, then clears
// - status bit 13 shows qsgmii sync, meaningful only on the first port
// - comma-detect bit 12 follows comma presence; a read sets it back to one
// - bits 11:8 show comma position 0 to 9, meaningless under qsgmii
// - good packet count in bits 13:0 modulo 10000; bit 15 shows counter active
// - select 00 picks media serdes counters, 01 mac serdes counters
// - preamble fix drops one extra preamble byte when preamble exceeds eight
// - crc error count in bits 7:0, saturating at 255
// - all transmit counters count only while the media link is up
// - bits 15:14 show remote fault sent to media in latest exchange
// - bit 13 enables media parallel detect, reset zero, only with autoneg on
// - bit 12 disables carrier extension on fiber links, resets to one
// - bit 11 forces advertising of media advertised word, resets zero
// - bits 6 and 5 invert media input and output polarity, reset zero
// - bit 4 set drops first preamble byte on odd start, clear delays one byte
// - bit 2 makes 100base-fx transmit halt line state continuously
// - bit 1 forces far-end fault to bit 0 value, clear leaves it automatic
// - mac control bit 11 makes the mac interface advertise the mac word
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`include "sdpcs_map.vh"
module sdpcs_regs (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire is_first_port,
    input wire qsgmii_mode,
    input wire [15:0] mac_lp_word,
    input wire mac_lp_word_valid,
    input wire mac_comma_realign,
    input wire mac_signal_detect,
    input wire qsgmii_sync,
    input wire mac_comma_present,
    input wire [3:0] mac_comma_pos,
    input wire media_link_up,
    input wire media_tx_good,
    input wire media_tx_crc_err,
    input wire mac_tx_good,
    input wire mac_tx_crc_err,
    input wire [1:0] media_rf_sent,
    input wire media_aneg_en,
    output reg [15:0] mac_adv_out,
    output reg mac_force_adv,
    output reg preamble_fix,
    output reg media_pd_en,
    output reg media_no_carrier_ext,
    output reg media_force_adv,
    output reg [15:0] media_adv_out,
    output reg media_pol_in_inv,
    output reg media_pol_out_inv,
    output reg media_odd_drop,
    output reg fx_force_hls,
    output reg fx_fefi_force,
    output reg fx_fefi_value
);

    reg [15:0] mac_lp;
    reg st_realign;
    reg st_sigdet;
    reg st_comma;
    reg [1:0] cnt_sel;
    reg [13:0] good_media;
    reg [13:0] good_mac;
    reg good_act_media;
    reg good_act_mac;
    reg [7:0] crc_media;
    reg [7:0] crc_mac;
    reg rd_done;
    reg pd_sticky;
    reg [15:0] next_rdata;

    wire [4:0] idx = avs_address[`SDPCS_ADDR_HI:`SDPCS_ADDR_LO];
    wire wr_lo = avs_write && avs_byteenable[0];
    wire wr_hi = avs_write && avs_byteenable[1];
    wire rd_take = avs_read && rd_done;
    wire rd_stat = rd_take && (idx == `SDPCS_IDX_MAC_STAT);

    function [13:0] mod_inc;
        input [13:0] v;
        begin
            if (v == `SDPCS_GOOD_MOD)
                mod_inc = 14'h0000;
            else
                mod_inc = v + 14'h0001;
        end
    endfunction

    // counter pick by select code, reserved codes read zero
    function [14:0] pick_count;
        input [1:0] sel;
        input act_mac;
        input [13:0] cnt_mac;
        input act_media;
        input [13:0] cnt_media;
        begin
            if (sel == `SDPCS_SEL_MAC)
                pick_count = {act_mac, cnt_mac};
            else if (sel == `SDPCS_SEL_MEDIA)
                pick_count = {act_media, cnt_media};
            else
                pick_count = 15'h0000;
        end
    endfunction

    function [7:0] sat_inc;
        input [7:0] v;
        begin
            if (v == `SDPCS_CRC_MAX)
                sat_inc = v;
            else
                sat_inc = v + 8'h01;
        end
    endfunction

    wire [14:0] good_pick = pick_count(cnt_sel, good_act_mac, good_mac, good_act_media, good_media);
    wire [14:0] crc_pick = pick_count(cnt_sel, 1'b0, {6'h00, crc_mac}, 1'b0, {6'h00, crc_media});

    // reads take one wait cycle, writes none
    assign avs_waitrequest = avs_read && !rd_done;

    always @(posedge ref_clk) begin
        if (rst)
            rd_done <= 1'b0;
        else
            rd_done <= avs_read && !rd_done;
    end

    // control registers
    always @(posedge ref_clk) begin
        if (rst) begin
            mac_force_adv <= `SDPCS_MAC_CTL_RST;
            mac_adv_out <= `SDPCS_MAC_ADV_RST;
            media_adv_out <= `SDPCS_MEDIA_ADV_RST;
            cnt_sel <= `SDPCS_SEL_RST;
            preamble_fix <= `SDPCS_PFIX_RST;
            pd_sticky <= `SDPCS_PD_RST;
            media_no_carrier_ext <= `SDPCS_NOCE_RST;
            media_force_adv <= `SDPCS_FADV_RST;
            media_pol_in_inv <= `SDPCS_POL_RST;
            media_pol_out_inv <= `SDPCS_POL_RST;
            media_odd_drop <= `SDPCS_ODD_RST;
            fx_force_hls <= `SDPCS_HLS_RST;
            fx_fefi_force <= `SDPCS_FEFI_RST;
            fx_fefi_value <= `SDPCS_FEFI_RST;
        end else begin
            if (wr_hi && idx == `SDPCS_IDX_MAC_CTL)
                mac_force_adv <= avs_writedata[`SDPCS_MAC_CTL_FADV];
            if (idx == `SDPCS_IDX_MAC_ADV && mac_force_adv) begin
                if (wr_lo)
                    mac_adv_out[7:0] <= avs_writedata[7:0];
                if (wr_hi)
                    mac_adv_out[15:8] <= avs_writedata[15:8];
            end
            if (idx == `SDPCS_IDX_MEDIA_ADV && media_force_adv) begin
                if (wr_lo)
                    media_adv_out[7:0] <= avs_writedata[7:0];
                if (wr_hi)
                    media_adv_out[15:8] <= avs_writedata[15:8];
            end
            if (wr_hi && idx == `SDPCS_IDX_TX_CRC) begin
                cnt_sel <= avs_writedata[`SDPCS_SEL_HI:`SDPCS_SEL_LO];
                preamble_fix <= avs_writedata[`SDPCS_PFIX_BIT];
            end
            if (wr_hi && idx == `SDPCS_IDX_MEDIA_CTL) begin
                pd_sticky <= avs_writedata[`SDPCS_PD_BIT];
                media_no_carrier_ext <= avs_writedata[`SDPCS_NOCE_BIT];
                media_force_adv <= avs_writedata[`SDPCS_FADV_BIT];
            end
            if (wr_lo && idx == `SDPCS_IDX_MEDIA_CTL) begin
                media_pol_in_inv <= avs_writedata[`SDPCS_POLIN_BIT];
                media_pol_out_inv <= avs_writedata[`SDPCS_POLOUT_BIT];
                media_odd_drop <= avs_writedata[`SDPCS_ODD_BIT];
                fx_force_hls <= avs_writedata[`SDPCS_HLS_BIT];
                fx_fefi_force <= avs_writedata[`SDPCS_FFEFI_BIT];
                fx_fefi_value <= avs_writedata[`SDPCS_FEFIV_BIT];
            end
        end
    end

    // parallel detect acts only while autonegotiation is on
    always @(posedge ref_clk) begin
        if (rst)
            media_pd_en <= `SDPCS_PD_RST;
        else
            media_pd_en <= pd_sticky && media_aneg_en;
    end

    // partner word and sticky status, event wins over read clear
    always @(posedge ref_clk) begin
        if (rst) begin
            mac_lp <= 16'h0000;
            st_realign <= 1'b0;
            st_sigdet <= 1'b0;
            st_comma <= 1'b0;
        end else begin
            if (mac_lp_word_valid)
                mac_lp <= mac_lp_word;
            if (mac_comma_realign)
                st_realign <= 1'b1;
            else if (rd_stat)
                st_realign <= 1'b0;
            if (mac_signal_detect)
                st_sigdet <= 1'b1;
            else if (rd_stat)
                st_sigdet <= 1'b0;
            if (rd_stat)
                st_comma <= 1'b1;
            else if (!mac_comma_present)
                st_comma <= 1'b0;
            else
                st_comma <= 1'b1;
        end
    end

    // transmit counters, both sets gated by media link
    always @(posedge ref_clk) begin
        if (rst) begin
            good_media <= 14'h0000;
            good_mac <= 14'h0000;
            good_act_media <= 1'b0;
            good_act_mac <= 1'b0;
            crc_media <= 8'h00;
            crc_mac <= 8'h00;
        end else if (media_link_up) begin
            good_act_media <= 1'b1;
            good_act_mac <= 1'b1;
            if (media_tx_good)
                good_media <= mod_inc(good_media);
            if (mac_tx_good)
                good_mac <= mod_inc(good_mac);
            if (media_tx_crc_err)
                crc_media <= sat_inc(crc_media);
            if (mac_tx_crc_err)
                crc_mac <= sat_inc(crc_mac);
        end else begin
            good_act_media <= 1'b0;
            good_act_mac <= 1'b0;
        end
    end

    // read mux, reserved bits zero
    always @* begin
        next_rdata = 16'h0000;
        case (idx)
            `SDPCS_IDX_MAC_CTL:
                next_rdata[`SDPCS_MAC_CTL_FADV] = mac_force_adv;
            `SDPCS_IDX_MAC_ADV:
                next_rdata = mac_adv_out;
            `SDPCS_IDX_MEDIA_ADV:
                next_rdata = media_adv_out;
            `SDPCS_IDX_MAC_LP:
                next_rdata = mac_lp;
            `SDPCS_IDX_MAC_STAT: begin
                next_rdata[15] = st_realign;
                next_rdata[14] = st_sigdet;
                next_rdata[13] = qsgmii_sync && is_first_port;
                next_rdata[12] = st_comma;
                next_rdata[11:8] = qsgmii_mode ? 4'h0 : mac_comma_pos;
            end
            `SDPCS_IDX_TX_GOOD: begin
                next_rdata[15] = good_pick[14];
                next_rdata[13:0] = good_pick[13:0];
            end
            `SDPCS_IDX_TX_CRC: begin
                next_rdata[15:14] = cnt_sel;
                next_rdata[13] = preamble_fix;
                next_rdata[7:0] = crc_pick[7:0];
            end
            `SDPCS_IDX_MEDIA_CTL: begin
                next_rdata[15:14] = media_rf_sent;
                next_rdata[13] = pd_sticky;
                next_rdata[12] = media_no_carrier_ext;
                next_rdata[11] = media_force_adv;
                next_rdata[6] = media_pol_in_inv;
                next_rdata[5] = media_pol_out_inv;
                next_rdata[4] = media_odd_drop;
                next_rdata[2] = fx_force_hls;
                next_rdata[1] = fx_fefi_force;
                next_rdata[0] = fx_fefi_value;
            end
            default:
                next_rdata = 16'h0000;
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst)
            avs_readdata <= 32'h00000000;
        else if (avs_read && !rd_done)
            avs_readdata <= {16'h0000, next_rdata};
    end

endmodule

// ### tb/sdpcs_mac_model.sv
// Purpose: mac side of the serdes link, sends ability words and packet events
// Assumes: one event per two clock cycles
// Notes: word lines show the inverse of the last word when not valid
`timescale 1ns/1ps
module sdpcs_mac_model (
    input wire ref_clk,
    output reg [15:0] mac_lp_word,
    output reg mac_lp_word_valid,
    output reg [3:0] pkt
);
    initial begin
        mac_lp_word = 16'h0000;
        mac_lp_word_valid = 1'h0;
        pkt = 4'h0;
    end
    task send_word(input [15:0] w);
        begin
            @(posedge ref_clk);
            mac_lp_word <= w;
            mac_lp_word_valid <= 1'h1;
            @(posedge ref_clk);
            mac_lp_word <= ~w;
            mac_lp_word_valid <= 1'h0;
        end
    endtask
    task send_pkts(input [3:0] kind, input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(posedge ref_clk);
                pkt <= kind;
                @(posedge ref_clk);
                pkt <= 4'h0;
            end
        end
    endtask
endmodule

// ### tb/sdpcs_regs_monitor.sv
// Purpose: bus and control-output checks for the serdes pcs register bank
// Assumes: reads wait one cycle, writes never wait
// Notes: bound to every sdpcs_regs instance
`timescale 1ns/1ps
module sdpcs_regs_monitor (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [15:0] mac_adv_out,
    input wire mac_force_adv,
    input wire media_no_carrier_ext,
    input wire media_odd_drop,
    input wire media_pol_in_inv,
    input wire media_pol_out_inv,
    input wire fx_force_hls
);
    wire rd_done = avs_read && !avs_waitrequest;
    wire [4:0] idx = avs_address[6:2];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("read wait");
    write_nowait_a: assert property (avs_write |-> !avs_waitrequest) else $error("write waited");
    upper_zero_a: assert property (rd_done |-> avs_readdata[31:16] == 16'h0000) else $error("upper bits");
    stat_fields_a: assert property (rd_done && idx == 5'h14 |-> avs_readdata[7:0] == 8'h00 && avs_readdata[11:8] <= 4'h9)
        else $error("status fields");
    good_range_a: assert property (rd_done && idx == 5'h15 |-> !avs_readdata[14] && avs_readdata[13:0] < 14'h2710)
        else $error("good count range");
    crc_resv_a: assert property (rd_done && idx == 5'h16 |-> avs_readdata[12:8] == 5'h00) else $error("crc reserved");
    mac_adv_lock_a: assert property (!mac_force_adv |=> $stable(mac_adv_out)) else $error("adv word changed");
    ctl_write_a: assert property (avs_write && idx == 5'h17 && avs_byteenable[0] |=> media_pol_in_inv == $past(avs_writedata[6])
        && media_pol_out_inv == $past(avs_writedata[5]) && fx_force_hls == $past(avs_writedata[2]))
        else $error("media control write");
    force_write_a: assert property (avs_write && idx == 5'h10 && avs_byteenable[1] |=> mac_force_adv == $past(avs_writedata[11]))
        else $error("force bit write");
    reset_val_a: assert property (disable iff (1'h0) rst |=> media_no_carrier_ext && media_odd_drop && !mac_force_adv)
        else $error("reset values");
endmodule
bind sdpcs_regs sdpcs_regs_monitor u_sdpcs_regs_monitor (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mac_adv_out(mac_adv_out),
    .mac_force_adv(mac_force_adv), .media_no_carrier_ext(media_no_carrier_ext), .media_odd_drop(media_odd_drop),
    .media_pol_in_inv(media_pol_in_inv), .media_pol_out_inv(media_pol_out_inv), .fx_force_hls(fx_force_hls));

// ### tb/test_serdes_pcs_ability_status_regs.sv
// Purpose: self-checking bench for the serdes pcs register bank
// Assumes: avalon reads answered after one wait cycle
// Notes: packet events come from sdpcs_mac_model
`timescale 1ns/1ps
module test_serdes_pcs_ability_status_regs;
    reg ref_clk = 1'h0, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
    reg [7:0] avs_address = 8'h00;
    reg [31:0] avs_writedata = 32'h00000000;
    reg first = 1'h0, qmode = 1'h0, realign = 1'h0, sdet = 1'h0, qsync = 1'h0, cpres = 1'h0, link = 1'h0;
    reg [3:0] cpos = 4'h0;
    reg [3:0] ben = 4'hF;
    reg [1:0] rf = 2'h0;
    reg [15:0] r;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, lp_val, mac_fadv, pfix, pd, noce, fadv, pin, pout, odd, hls, fforce, fval;
    wire [15:0] lp_word, mac_adv, media_adv;
    wire [3:0] pkt;
    integer err_count = 0, check_count = 0;
    sdpcs_mac_model u_sdpcs_mac_model (.ref_clk(ref_clk), .mac_lp_word(lp_word), .mac_lp_word_valid(lp_val), .pkt(pkt));
    sdpcs_regs u_sdpcs_regs (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(ben), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .is_first_port(first), .qsgmii_mode(qmode), .mac_lp_word(lp_word),
        .mac_lp_word_valid(lp_val), .mac_comma_realign(realign), .mac_signal_detect(sdet), .qsgmii_sync(qsync),
        .mac_comma_present(cpres), .mac_comma_pos(cpos), .media_link_up(link), .media_tx_good(pkt[3]),
        .media_tx_crc_err(pkt[2]), .mac_tx_good(pkt[1]), .mac_tx_crc_err(pkt[0]), .media_rf_sent(rf),
        .media_aneg_en(1'h1), .mac_adv_out(mac_adv), .mac_force_adv(mac_fadv), .preamble_fix(pfix), .media_pd_en(pd),
        .media_no_carrier_ext(noce), .media_force_adv(fadv), .media_adv_out(media_adv), .media_pol_in_inv(pin),
        .media_pol_out_inv(pout), .media_odd_drop(odd), .fx_force_hls(hls), .fx_fefi_force(fforce), .fx_fefi_value(fval));
    initial forever #12.5 ref_clk = ~ref_clk;
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        #1000000;
        err_count = err_count + 1;
        stop_test;
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task bus(input rd, input [7:0] a, input [15:0] wd);
        integer n;
        begin
            n = 0;
            @(posedge ref_clk);
            avs_read <= rd;
            avs_write <= !rd;
            avs_address <= a;
            avs_writedata <= {16'h0000, wd};
            @(posedge ref_clk);
            while (avs_waitrequest !== 1'h0 && n < 20) begin
                @(posedge ref_clk);
                n = n + 1;
            end
            if (n == 20) err_count = err_count + 1;
            r = avs_readdata[15:0];
            avs_read <= 1'h0;
            avs_write <= 1'h0;
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        bus(1'h0, a, d);
    endtask
    task rd(input [7:0] a, input [15:0] e);
        begin
            bus(1'h1, a, 16'h0000);
            chk(r, e);
        end
    endtask
    task t_regs;
        begin
            rd(8'h5C, 16'h1010);
            wr(8'h48, 16'hABCD);
            chk(mac_adv, 16'h0000);
            wr(8'h40, 16'h0800);
            wr(8'h48, 16'hABCD);
            rd(8'h48, 16'hABCD);
            chk(mac_adv, 16'hABCD);
            @(posedge ref_clk);
            ben <= 4'h1;
            wr(8'h48, 16'h1200);
            @(posedge ref_clk);
            ben <= 4'hF;
            rd(8'h48, 16'hAB00);
            rd(8'h7C, 16'h0000);
            u_sdpcs_mac_model.send_word(16'h1234);
            wr(8'h4C, 16'h5555);
            rd(8'h4C, 16'h1234);
            $display("register test done");
        end
    endtask
    task t_stat;
        begin
            @(posedge ref_clk);
            {realign, sdet, cpres, first, qsync, cpos} <= {5'h1F, 4'h9};
            @(posedge ref_clk);
            {realign, sdet} <= 2'h0;
            rd(8'h50, 16'hF900);
            @(posedge ref_clk);
            {cpres, first} <= 2'h0;
            rd(8'h50, 16'h0900);
            @(posedge ref_clk);
            qmode <= 1'h1;
            rd(8'h50, 16'h0000);
            $display("status test done");
        end
    endtask
    task t_cnt;
        begin
            @(posedge ref_clk);
            link <= 1'h1;
            u_sdpcs_mac_model.send_pkts(4'h8, 3);
            u_sdpcs_mac_model.send_pkts(4'h4, 2);
            u_sdpcs_mac_model.send_pkts(4'h2, 10001);
            u_sdpcs_mac_model.send_pkts(4'h1, 300);
            rd(8'h54, 16'h8003);
            @(posedge ref_clk);
            link <= 1'h0;
            u_sdpcs_mac_model.send_pkts(4'hF, 5);
            rd(8'h54, 16'h0003);
            rd(8'h58, 16'h0002);
            wr(8'h58, 16'h4000);
            rd(8'h54, 16'h0001);
            rd(8'h58, 16'h40FF);
            wr(8'h58, 16'hBFFF);
            rd(8'h58, 16'hA000);
            chk({15'h0000, pfix}, 16'h0001);
            $display("counter test done");
        end
    endtask
    task t_media;
        begin
            @(posedge ref_clk);
            rf <= 2'h2;
            wr(8'h5C, 16'h0800);
            wr(8'h64, 16'h0020);
            wr(8'h5C, 16'hFFFF);
            rd(8'h5C, 16'hB877);
            chk({pd, noce, fadv, pin, pout, odd, hls, fforce, fval, media_adv[6:0]}, 16'hFFA0);
            wr(8'h5C, 16'h0001);
            wr(8'h64, 16'h1111);
            rd(8'h5C, 16'h8001);
            chk({fforce, fval, fadv, noce, odd, media_adv[10:0]}, 16'h4020);
            $display("media control test done");
        end
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        t_regs;
        t_stat;
        t_cnt;
        t_media;
        stop_test;
    end
endmodule
